/* File: src/adc_result_status_regs.sv */
// Result and status registers of the converter with bus slave and interrupt
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_result_status_regs
	import adc_res_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              conv_start,
	input  wire logic              conv_done,
	input  wire logic [RES_W-1:0]  conv_result,
	input  wire logic              conv_disable,
	input  wire logic              stop_enter,
	output logic                   conversion_done_irq,
	output logic                   irq
);
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_ok;
	logic              rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_data;
	logic              rd_ok;

	conv_state_e       state_r;
	conv_state_e       state_nxt;
	logic [7:0]        result_high_reg_r;
	logic [1:0]        result_low_r;
	logic              conversion_done_flag_r;
	logic              conversion_done_irq_r;
	logic [IRQ_W-1:0]  irq_status_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [IRQ_W-1:0]  irq_clear;
	logic [IRQ_W-1:0]  irq_event;
	logic [3:0]        noise_r;
	logic              busy;
	logic              start_ok;
	logic              done_ok;
	logic              stop_abort;
	logic              high_read;
	logic [7:0]        low_view;
	logic [ADDR_W-1:0] wr_word;
	logic [ADDR_W-1:0] rd_word;

	axil_reg_port u_port (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	// Byte offsets within a word are ignored; registers are word aligned
	assign wr_word = {wr_addr[ADDR_W-1:2], 2'b00};
	assign rd_word = {rd_addr[ADDR_W-1:2], 2'b00};

	assign busy       = (state_r == CONV_RUN);
	assign start_ok   = conv_start && !stop_enter && !conv_disable;
	// Stop or disable in the finishing cycle wins, so the result is dropped
	assign done_ok    = conv_done && busy && !stop_enter && !conv_disable;
	assign stop_abort = stop_enter && busy;
	assign high_read  = rd_en && (rd_word == OFF_RES_HIGH);

	// Conversion tracking; a finish and a restart in one cycle keep it running
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CONV_IDLE: begin
				if (start_ok)
					state_nxt = CONV_RUN;
			end
			CONV_RUN: begin
				if (stop_enter || conv_disable)
					state_nxt = CONV_IDLE;
				else if (conv_done && !conv_start)
					state_nxt = CONV_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_r <= CONV_IDLE;
		else
			state_r <= state_nxt;
	end

	// Results only change on a finished conversion or a stop abort
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_high_reg_r <= RES_HIGH_RST;
			result_low_r      <= RES_LOW_RST;
		end else if (stop_abort) begin
			result_high_reg_r <= RES_HIGH_RST;
			result_low_r      <= RES_LOW_RST;
		end else if (done_ok) begin
			result_high_reg_r <= conv_result[RES_W-1:2];
			result_low_r      <= conv_result[1:0];
		end
	end

	// A completion in the same cycle as the clearing read wins
	always_ff @(posedge aclk) begin
		if (!aresetn)
			conversion_done_flag_r <= 1'b0;
		else if (done_ok)
			conversion_done_flag_r <= 1'b1;
		else if (start_ok || stop_abort)
			conversion_done_flag_r <= 1'b0;
		else if (high_read)
			conversion_done_flag_r <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			conversion_done_irq_r <= 1'b0;
		else
			conversion_done_irq_r <= done_ok;
	end

	assign conversion_done_irq = conversion_done_irq_r;

	// Free counter stands in for the undriven low nibble; software must not rely on it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			noise_r <= NOISE_RST;
		else
			noise_r <= noise_r + 4'h1;
	end

	assign low_view = {result_low_r, conversion_done_flag_r, busy, noise_r};

	assign irq_event[IRQ_DONE_BIT]  = done_ok;
	assign irq_event[IRQ_ABORT_BIT] = stop_abort;
	assign irq_clear = (wr_en && wr_word == OFF_IRQ_STAT && wr_strb[0]) ?
		wr_data[IRQ_W-1:0] : '0;

	// Write-one-to-clear; a new event in the clearing cycle stays set
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_status_r <= IRQ_STAT_RST;
		else
			irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_mask_r <= IRQ_MASK_RST;
		else if (wr_en && wr_word == OFF_IRQ_MASK && wr_strb[0])
			irq_mask_r <= wr_data[IRQ_W-1:0];
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// Result registers accept writes silently; only unmapped words answer with an error
	assign wr_ok = (wr_word == OFF_RES_HIGH) || (wr_word == OFF_RES_LOW) ||
		(wr_word == OFF_IRQ_STAT) || (wr_word == OFF_IRQ_MASK);
	assign rd_ok = (rd_word == OFF_RES_HIGH) || (rd_word == OFF_RES_LOW) ||
		(rd_word == OFF_IRQ_STAT) || (rd_word == OFF_IRQ_MASK);

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_word)
			OFF_RES_HIGH: rd_data[7:0] = result_high_reg_r;
			OFF_RES_LOW:  rd_data[7:0] = low_view;
			OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_status_r;
			OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_r;
			default:      rd_data = 32'h0000_0000;
		endcase
	end

	// Every check runs on the bus clock and sleeps through reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_started;
		conv_start && !busy && !stop_enter && !conv_disable;
	endsequence

	// A finish only counts while the conversion is still running
	sequence s_finish_now;
		conv_done && busy && !conv_start && !stop_enter && !conv_disable;
	endsequence

	sequence s_done_unread;
		conversion_done_flag_r && !busy;
	endsequence

	property p_full_conversion;
		s_started ##[1:8] s_finish_now |=> conversion_done_flag_r && !busy &&
			result_high_reg_r == $past(conv_result[RES_W-1:2]);
	endproperty

	property p_restart_keeps;
		s_done_unread ##0 s_started |=> !conversion_done_flag_r && busy &&
			$stable(result_high_reg_r) && $stable(result_low_r);
	endproperty

	a_full_conversion: assert property (p_full_conversion)
		else $error("conversion did not finish with result and done flag");

	a_restart_keeps: assert property (p_restart_keeps)
		else $error("restart changed result or left done flag set");

	a_result_load: assert property (done_ok |=>
		result_high_reg_r == $past(conv_result[9:2]) &&
		result_low_r == $past(conv_result[1:0]) && conversion_done_irq)
		else $error("result not loaded with interrupt pulse");

	a_low_layout: assert property (rd_en && rd_word == OFF_RES_LOW |=>
		rdata[7:4] == {$past(result_low_r), $past(conversion_done_flag_r), $past(busy)} &&
		rdata[31:8] == 24'h00_0000)
		else $error("low result register layout wrong");

	a_done_zero_run: assert property ($rose(busy) |-> !conversion_done_flag_r)
		else $error("done flag set while conversion starts");

	a_done_stays_low: assert property (busy && !conversion_done_flag_r && !done_ok |=>
		!conversion_done_flag_r)
		else $error("done flag rose without completion");

	a_busy_idle_zero: assert property (conv_done && busy && !conv_start |=>
		!busy ##1 (!busy || $past(conv_start)))
		else $error("busy flag set with no conversion running");

	a_high_read_clr: assert property (high_read && !done_ok |=> !conversion_done_flag_r)
		else $error("reading high result did not clear done flag");

	a_busy_on_start: assert property (start_ok |=> busy)
		else $error("busy flag not set at start");

	a_stop_clears: assert property (stop_enter |=> !busy && !conversion_done_irq)
		else $error("stop did not clear busy flag");

	a_stop_abort: assert property (stop_abort |=>
		result_high_reg_r == 8'h00 && result_low_r == 2'h0 && !conversion_done_flag_r)
		else $error("stop during conversion kept result");

	a_disable_abort: assert property (conv_disable && busy && !stop_enter |=>
		!busy && $stable(result_high_reg_r) && !conversion_done_irq &&
		(!conversion_done_flag_r || $past(conversion_done_flag_r)))
		else $error("disable updated result or done flag");

	a_irq_raise: assert property (done_ok && irq_mask_r[IRQ_DONE_BIT] |=> irq [*2])
		else $error("masked-in completion did not hold interrupt");

	// Status bits record each event for software, whatever the mask holds
	a_status_done_set: assert property (done_ok |=> irq_status_r[IRQ_DONE_BIT])
		else $error("completion did not set its status bit");

	a_status_abort_set: assert property (stop_abort |=> irq_status_r[IRQ_ABORT_BIT])
		else $error("stop abort did not set its status bit");

	sequence s_clear_done_status;
		wr_en && wr_word == OFF_IRQ_STAT && wr_strb[0] && wr_data[IRQ_DONE_BIT] && !done_ok;
	endsequence

	a_status_w1c: assert property (s_clear_done_status |=> !irq_status_r[IRQ_DONE_BIT])
		else $error("write of one did not clear completion status");

	a_mask_write: assert property (wr_en && wr_word == OFF_IRQ_MASK && wr_strb[0] |=>
		irq_mask_r == $past(wr_data[IRQ_W-1:0]))
		else $error("mask register did not take written value");

	// Results are read-only; a bus write must never reach them
	a_result_ro: assert property (wr_en && !done_ok && !stop_abort |=>
		$stable(result_high_reg_r) && $stable(result_low_r))
		else $error("bus write changed a result register");

	// A rising done flag must follow a running conversion; busy edges must each have a cause at the strobes
	a_done_from_run: assert property ($rose(conversion_done_flag_r) |-> $past(busy))
		else $error("done flag rose without a running conversion");

	a_busy_from_start: assert property ($rose(busy) |-> $past(conv_start))
		else $error("busy flag rose without a start");

	a_busy_end_cause: assert property ($fell(busy) |->
		$past(conv_done) || $past(stop_enter) || $past(conv_disable))
		else $error("busy flag fell while conversion still running");

	// Restart hides the old completion; the result itself stays until replaced or cleared by a stop abort
	a_start_clears_done: assert property (start_ok && !done_ok |=>
		!conversion_done_flag_r)
		else $error("start left the done flag set");

	// Of the two result reads, only the high register read clears the flag, so the low one can be polled
	a_low_read_keeps: assert property (rd_en && rd_word == OFF_RES_LOW && !done_ok &&
		!start_ok && !stop_abort |=> $stable(conversion_done_flag_r))
		else $error("reading low register changed the done flag");

	// Stop while idle leaves nothing to abort, so results survive
	a_stop_idle_keeps: assert property (stop_enter && !busy |=>
		$stable(result_high_reg_r) && $stable(result_low_r))
		else $error("stop while idle changed a result register");

	// Bus errors only come from unmapped words
	a_unmapped_err: assert property (rd_en && !rd_ok |=>
		rresp == RESP_SLVERR && rdata == 32'h0000_0000)
		else $error("unmapped read did not answer with error and zero");

	a_wr_error: assert property (wr_en && !wr_ok |=> bvalid && bresp == RESP_SLVERR)
		else $error("unmapped write did not answer with error");

	a_single_write: assert property (wr_en |=> !wr_en && bvalid)
		else $error("write applied twice or left unanswered");

	a_read_answer: assert property (rd_en |=> rvalid)
		else $error("read address taken without an answer");
endmodule // adc_result_status_regs

/* File: src/adc_res_pkg.sv */
// Package: register map, layouts and constants of the converter result/status block
package adc_res_pkg;
	localparam int         ADDR_W        = 8;
	localparam int         RES_W         = 10;
	localparam int         IRQ_W         = 2;
	localparam logic [7:0] OFF_RES_HIGH  = 8'h00;
	localparam logic [7:0] OFF_RES_LOW   = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h0C;
	localparam logic [7:0] RES_HIGH_RST  = 8'h00;
	localparam logic [1:0] RES_LOW_RST   = 2'h0;
	localparam logic [1:0] IRQ_STAT_RST  = 2'h0;
	localparam logic [1:0] IRQ_MASK_RST  = 2'h0;
	localparam logic [3:0] NOISE_RST     = 4'h0;
	localparam int         DONE_BIT      = 5;
	localparam int         BUSY_BIT      = 4;
	localparam int         IRQ_DONE_BIT  = 0;
	localparam int         IRQ_ABORT_BIT = 1;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic {
		CONV_IDLE = 1'b0,
		CONV_RUN  = 1'b1
	} conv_state_e;
endpackage

/* File: src/axil_reg_port.sv */
// AXI4-Lite slave front end turning bus beats into register strobes
`timescale 1ns/1ps
module axil_reg_port
	import adc_res_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_ok,
	output logic                   rd_en,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);
	logic aw_held_r;
	logic w_held_r;

	assign awready = !aw_held_r && !bvalid;
	assign wready  = !w_held_r && !bvalid;
	assign wr_en   = aw_held_r && w_held_r && !bvalid;
	assign arready = !rvalid;
	assign rd_en   = arvalid && arready;
	assign rd_addr = araddr;

	// Address and data are latched separately so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			wr_addr   <= '0;
			wr_data   <= '0;
			wr_strb   <= '0;
		end else if (wr_en) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				wr_addr   <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				wr_data  <= wdata;
				wr_strb  <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid <= 1'b1;
			bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read data is captured at the address beat, which is also when read side effects fire
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (rd_en) begin
			rvalid <= 1'b1;
			rdata  <= rd_data;
			rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule // axil_reg_port

/* File: dv/cpu_bus_model.sv */
// Bus master model of the CPU core that reaches the result and status registers
`timescale 1ns/1ps
module cpu_bus_model
	import adc_res_pkg::*;
(
	input  wire logic              aclk,
	output logic [ADDR_W-1:0]      awaddr,
	output logic                   awvalid,
	input  wire logic              awready,
	output logic [31:0]            wdata,
	output logic [3:0]             wstrb,
	output logic                   wvalid,
	input  wire logic              wready,
	input  wire logic [1:0]        bresp,
	input  wire logic              bvalid,
	output logic                   bready,
	output logic [ADDR_W-1:0]      araddr,
	output logic                   arvalid,
	input  wire logic              arready,
	input  wire logic [31:0]       rdata,
	input  wire logic [1:0]        rresp,
	input  wire logic              rvalid,
	output logic                   rready
);
	initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

	// Released payloads are inverted so a slave cannot lean on stale values
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule // cpu_bus_model

/* File: dv/adc_result_status_regs_test.sv */
// Self-checking bench of the converter result and status registers
`timescale 1ns/1ps
module adc_result_status_regs_test;
	import adc_res_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] M   = 32'hFFFFFFF0; // Low nibble is unstable
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, conv_start, conv_done;
	logic              conv_disable, stop_enter, conversion_done_irq, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, d;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r;
	logic [RES_W-1:0]  conv_result;
	int                n_fail = 0;
	int                n_tests = 0;

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	adc_result_status_regs DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .conv_start(conv_start), .conv_done(conv_done),
		.conv_result(conv_result), .conv_disable(conv_disable), .stop_enter(stop_enter),
		.conversion_done_irq(conversion_done_irq), .irq(irq));

	cpu_bus_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	task automatic final_report();
		if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		cpu.rd(a, d, r);
		chk(d & m, e);
	endtask

	// One-cycle converter strobes, then the done interrupt pulse is checked
	task automatic conv(input logic st, dn, dis, stp, input logic [9:0] v, input logic ei);
		@(posedge aclk);
		{conv_start, conv_done, conv_disable, stop_enter} <= {st, dn, dis, stp};
		conv_result <= v;
		@(posedge aclk);
		{conv_start, conv_done, conv_disable, stop_enter} <= 4'h0;
		conv_result <= ~v;
		#1 chk({31'h0, conversion_done_irq}, {31'h0, ei});
	endtask

	initial begin
		repeat (5000) @(posedge aclk);
		n_fail++;
		final_report();
	end

	initial begin
		aresetn = 1'b0;
		{conv_start, conv_done, conv_disable, stop_enter} = 4'h0;
		conv_result = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFF_RES_HIGH, ALL, 32'h0);
		rchk(OFF_RES_LOW, M, 32'h0);
		rchk(OFF_IRQ_STAT, ALL, 32'h0);
		rchk(OFF_IRQ_MASK, ALL, 32'h0);
		conv(1, 0, 0, 0, 10'h000, 0);
		rchk(OFF_RES_LOW, M, 32'h10);
		conv(0, 1, 0, 0, 10'h2D6, 1);
		rchk(OFF_RES_LOW, M, 32'hA0);
		chk({31'h0, irq}, 32'h0);
		rchk(OFF_RES_HIGH, ALL, 32'hB5);
		rchk(OFF_RES_LOW, M, 32'h80);
		cpu.wr(OFF_IRQ_MASK, 32'h1, r);
		chk({31'h0, irq}, 32'h1);
		cpu.wr(OFF_IRQ_STAT, 32'h1, r);
		chk({31'h0, irq}, 32'h0);
		rchk(OFF_IRQ_STAT, ALL, 32'h0);
		// Restart before the result is read keeps the old value
		conv(1, 0, 0, 0, 10'h000, 0);
		conv(0, 1, 0, 0, 10'h0FF, 1);
		conv(1, 0, 0, 0, 10'h000, 0);
		rchk(OFF_RES_LOW, M, 32'hD0);
		rchk(OFF_RES_HIGH, ALL, 32'h3F);
		conv(1, 1, 0, 0, 10'h301, 1);
		rchk(OFF_RES_LOW, M, 32'h70);
		conv(0, 0, 1, 0, 10'h000, 0);
		rchk(OFF_RES_LOW, M, 32'h60);
		conv(0, 1, 0, 0, 10'h3FF, 0);
		rchk(OFF_RES_HIGH, ALL, 32'hC0);
		rchk(OFF_RES_LOW, M, 32'h40);
		conv(0, 0, 0, 1, 10'h000, 0);
		rchk(OFF_RES_HIGH, ALL, 32'hC0);
		cpu.wr(OFF_IRQ_STAT, 32'h3, r);
		conv(1, 0, 0, 0, 10'h000, 0);
		conv(0, 0, 0, 1, 10'h000, 0);
		rchk(OFF_RES_LOW, M, 32'h0);
		rchk(OFF_RES_HIGH, ALL, 32'h0);
		rchk(OFF_IRQ_STAT, ALL, 32'h2);
		chk({31'h0, irq}, 32'h0);
		cpu.wr(OFF_IRQ_MASK, 32'h3, r);
		chk({31'h0, irq}, 32'h1);
		cpu.rd(8'h10, d, r);
		chk({d[31:2], r}, {30'h0, RESP_SLVERR});
		cpu.wr(8'h14, 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		cpu.wr(OFF_RES_HIGH, 32'hFF, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		rchk(OFF_RES_HIGH, ALL, 32'h0);
		final_report();
	end
endmodule // adc_result_status_regs_test
